//--- logic/scfl_top.sv
`timescale 1ns/100ps
// Summary of operation
// - Tx flags pollable; zero mask blocks interrupt
// - Rx full cleared by status then data read
// - Idle cleared by status then data read
// - Idle rearms only after new received character
// - Error flags set together with rx full
// - No error flags for overrunning character
// - Overrun keeps old character, drops new one
// - Falling rx line edge sets edge flag while receiver is on
// - Edge flag cleared by writing one
// - Frame width bit selects nine-bit characters
// - Ninth bits held in control three
// - Ninth bit copied with data into shifter
module scfl_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Receive line and receive shifter
  input  wire logic        rxd,
  input  wire logic        rx_char_valid,
  input  wire logic [8:0]  rx_char_data,
  input  wire logic        rx_noise,
  input  wire logic        rx_framing,
  input  wire logic        rx_parity,
  input  wire logic        rx_line_idle,
  // Transmit shifter
  input  wire logic        tx_shift_ready,
  input  wire logic        tx_shift_idle,
  output logic             tx_shift_load,
  output logic [8:0]       tx_shift_word,
  // Interrupt
  output logic             irq
);

  typedef struct packed {
    scfl_pkg::scfl_acc_t acc;
    logic [31:0]         rdata;
    logic                err;
    logic                frame_nine;
    logic                rx_on;
    logic                tx_ninth;
    logic                rx_ninth;
    logic [7:0]          rx_data;
    logic [5:0]          rxf;
    logic [5:0]          arm;
    logic                idle_ok;
    logic                edge_flag;
    logic                rxd_q;
    logic [8:0]          fl_q;
    logic [8:0]          evt;
    logic [8:0]          mask;
  } scfl_main_st_t;

  scfl_main_st_t s_ff;
  scfl_main_st_t nxt_s;
  scfl_tx_if     tx_bus ();

  // Address decode, reused by every register access
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = hit(a, scfl_pkg::OFF_CTRL1) || hit(a, scfl_pkg::OFF_CTRL2) ||
             hit(a, scfl_pkg::OFF_STAT1) || hit(a, scfl_pkg::OFF_STAT2) ||
             hit(a, scfl_pkg::OFF_CTRL3) || hit(a, scfl_pkg::OFF_DATA)  ||
             hit(a, scfl_pkg::OFF_EVT)   || hit(a, scfl_pkg::OFF_MASK);
  endfunction : mapped

  logic       xfer;
  logic       wr;
  logic       rd;
  logic       st_rd;
  logic       dt_rd;
  logic [5:0] clr;
  logic       ovr;
  logic       take;
  logic       edge_seen;
  logic [8:0] all_fl;

  // One wait state: data is registered, side effects land on the last edge
  assign pready  = (s_ff.acc == scfl_pkg::ACC_ANSWER);
  assign prdata  = s_ff.rdata;
  assign pslverr = pready && s_ff.err;
  assign xfer    = psel && penable && pready;
  assign wr      = xfer && pwrite && !s_ff.err;
  assign rd      = xfer && !pwrite && !s_ff.err;
  assign st_rd   = rd && hit(paddr, scfl_pkg::OFF_STAT1);
  assign dt_rd   = rd && hit(paddr, scfl_pkg::OFF_DATA);

  // Data read clears only the flags that the earlier status read saw
  assign clr = dt_rd ? s_ff.arm : 6'h00;

  // A character arriving while the buffer stays full is an overrun
  assign ovr  = rx_char_valid && s_ff.rx_on &&
                s_ff.rxf[scfl_pkg::FL_RX_FULL] && !clr[scfl_pkg::FL_RX_FULL];
  assign take = rx_char_valid && s_ff.rx_on && !ovr;

  // Start bit is the active edge; rxd is already synchronous to pclk
  assign edge_seen = s_ff.rx_on && s_ff.rxd_q && !rxd;

  assign all_fl = {s_ff.edge_flag, tx_bus.tbe, tx_bus.tdone, s_ff.rxf};

  // Hand-off to the transmit holding stage
  assign tx_bus.wr    = wr && hit(paddr, scfl_pkg::OFF_DATA);
  assign tx_bus.wdata = pwdata[7:0];
  assign tx_bus.ninth = s_ff.frame_nine && s_ff.tx_ninth;
  assign tx_bus.seen  = st_rd && s_ff.rdata[scfl_pkg::FL_TX_EMPTY];

  // Level interrupt; masked-off flags stay pollable in status one, the edge flag in status two
  assign irq = |(s_ff.evt & s_ff.mask);

  // Next-state logic for the whole block except the transmit holding stage
  always_comb begin
    nxt_s = s_ff;
    // APB sequencer and read data capture
    case (s_ff.acc)
      scfl_pkg::ACC_IDLE: begin
        if (psel && penable) begin
          nxt_s.acc   = scfl_pkg::ACC_ANSWER;
          nxt_s.err   = !mapped(paddr);
          nxt_s.rdata = 32'h0000_0000;
          case (paddr)
            scfl_pkg::OFF_CTRL1: nxt_s.rdata[scfl_pkg::POS_FRAME_NINE] = s_ff.frame_nine;
            scfl_pkg::OFF_CTRL2: nxt_s.rdata[scfl_pkg::POS_RX_ON] = s_ff.rx_on;
            scfl_pkg::OFF_STAT1: nxt_s.rdata[7:0] = all_fl[7:0];
            scfl_pkg::OFF_STAT2: nxt_s.rdata[scfl_pkg::POS_EDGE] = s_ff.edge_flag;
            scfl_pkg::OFF_CTRL3: begin
              nxt_s.rdata[scfl_pkg::POS_RX_NINTH] = s_ff.rx_ninth;
              nxt_s.rdata[scfl_pkg::POS_TX_NINTH] = s_ff.tx_ninth;
            end
            scfl_pkg::OFF_DATA: nxt_s.rdata[7:0] = s_ff.rx_data;
            scfl_pkg::OFF_EVT:  nxt_s.rdata[8:0] = s_ff.evt;
            scfl_pkg::OFF_MASK: nxt_s.rdata[8:0] = s_ff.mask;
            default:            nxt_s.rdata = 32'h0000_0000;
          endcase
        end
      end
      scfl_pkg::ACC_ANSWER: nxt_s.acc = scfl_pkg::ACC_IDLE;
      default:              nxt_s.acc = scfl_pkg::ACC_IDLE;
    endcase

    // Control and mask register writes
    if (wr && hit(paddr, scfl_pkg::OFF_CTRL1)) begin
      nxt_s.frame_nine = pwdata[scfl_pkg::POS_FRAME_NINE];
    end
    if (wr && hit(paddr, scfl_pkg::OFF_CTRL2)) begin
      nxt_s.rx_on = pwdata[scfl_pkg::POS_RX_ON];
    end
    if (wr && hit(paddr, scfl_pkg::OFF_CTRL3)) begin
      nxt_s.tx_ninth = pwdata[scfl_pkg::POS_TX_NINTH];
    end
    if (wr && hit(paddr, scfl_pkg::OFF_MASK)) begin
      nxt_s.mask = pwdata[8:0];
    end

    // Two-step clear: status read arms, data read clears
    if (st_rd) begin
      nxt_s.arm = s_ff.rdata[5:0];
    end
    if (dt_rd) begin
      nxt_s.arm = 6'h00;
    end
    nxt_s.rxf = s_ff.rxf & ~clr;
    if (clr[scfl_pkg::FL_IDLE]) begin
      nxt_s.idle_ok = 1'b0;
    end

    // New character: buffer it with its errors, or flag overrun
    if (take) begin
      nxt_s.rx_data  = rx_char_data[7:0];
      nxt_s.rx_ninth = s_ff.frame_nine && rx_char_data[8];
      nxt_s.rxf[scfl_pkg::FL_RX_FULL] = 1'b1;
      nxt_s.rxf[scfl_pkg::FL_NOISE]   = nxt_s.rxf[scfl_pkg::FL_NOISE]   | rx_noise;
      nxt_s.rxf[scfl_pkg::FL_FRAMING] = nxt_s.rxf[scfl_pkg::FL_FRAMING] | rx_framing;
      nxt_s.rxf[scfl_pkg::FL_PARITY]  = nxt_s.rxf[scfl_pkg::FL_PARITY]  | rx_parity;
      nxt_s.idle_ok = 1'b1;
    end
    // Overrun drops the new character and its errors
    if (ovr) begin
      nxt_s.rxf[scfl_pkg::FL_OVERRUN] = 1'b1;
    end

    // Idle only once per received character
    if (rx_line_idle && s_ff.rx_on && s_ff.idle_ok) begin
      nxt_s.rxf[scfl_pkg::FL_IDLE] = 1'b1;
    end

    // Edge flag: write one clears, a new edge wins over the clear
    nxt_s.rxd_q = rxd;
    if (wr && hit(paddr, scfl_pkg::OFF_STAT2) && pwdata[scfl_pkg::POS_EDGE]) begin
      nxt_s.edge_flag = 1'b0;
    end
    if (edge_seen) begin
      nxt_s.edge_flag = 1'b1;
    end

    // Sticky events on each rising flag; set wins over write-one clear
    nxt_s.fl_q = all_fl;
    if (wr && hit(paddr, scfl_pkg::OFF_EVT)) begin
      nxt_s.evt = s_ff.evt & ~pwdata[8:0];
    end
    nxt_s.evt = nxt_s.evt | (all_fl & ~s_ff.fl_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '{acc: scfl_pkg::ACC_IDLE, rdata: 32'h0000_0000, err: 1'b0,
                frame_nine: 1'b0, rx_on: 1'b0, tx_ninth: 1'b0, rx_ninth: 1'b0,
                rx_data: 8'h00, rxf: scfl_pkg::RXF_RST, arm: 6'h00,
                idle_ok: 1'b1, edge_flag: 1'b0, rxd_q: 1'b1,
                fl_q: scfl_pkg::FLAGS_RST, evt: 9'h000, mask: scfl_pkg::MASK_RST};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Transmit holding stage
  scfl_tx_hold u_tx (
    .pclk           (pclk),
    .presetn        (presetn),
    .bus            (tx_bus.tx),
    .tx_shift_ready (tx_shift_ready),
    .tx_shift_idle  (tx_shift_idle),
    .tx_shift_load  (tx_shift_load),
    .tx_shift_word  (tx_shift_word)
  );

  // Checks on the flag logic
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tx_mask_gate;
    (s_ff.mask[7:6] == 2'b00 && (s_ff.evt[5:0] & s_ff.mask[5:0]) == 6'h00 &&
     !(s_ff.evt[8] && s_ff.mask[8]) && (tx_bus.tbe || tx_bus.tdone)) |-> !irq;
  endproperty
  a_tx_mask_gate: assert property (p_tx_mask_gate)
    else $error("masked tx flag raised interrupt");

  property p_full_clear;
    $fell(s_ff.rxf[scfl_pkg::FL_RX_FULL]) |-> $past(dt_rd) &&
      $past(s_ff.arm[scfl_pkg::FL_RX_FULL]);
  endproperty
  a_full_clear: assert property (p_full_clear)
    else $error("rx full cleared without sequence");

  property p_idle_clear;
    $fell(s_ff.rxf[scfl_pkg::FL_IDLE]) |-> $past(dt_rd) &&
      $past(s_ff.arm[scfl_pkg::FL_IDLE]);
  endproperty
  a_idle_clear: assert property (p_idle_clear)
    else $error("idle cleared without sequence");

  property p_idle_rearm;
    $fell(s_ff.rxf[scfl_pkg::FL_IDLE]) ##1 !take [*2] |-> !s_ff.rxf[scfl_pkg::FL_IDLE];
  endproperty
  a_idle_rearm: assert property (p_idle_rearm)
    else $error("idle set again without new character");

  property p_err_with_full;
    take && rx_framing |=> s_ff.rxf[scfl_pkg::FL_RX_FULL] &&
      s_ff.rxf[scfl_pkg::FL_FRAMING];
  endproperty
  a_err_with_full: assert property (p_err_with_full)
    else $error("framing error not set with rx full");

  property p_ovr_no_err;
    ovr && !s_ff.rxf[scfl_pkg::FL_NOISE] && !take |=> !s_ff.rxf[scfl_pkg::FL_NOISE];
  endproperty
  a_ovr_no_err: assert property (p_ovr_no_err)
    else $error("noise flag set on overrun");

  property p_ovr_keep;
    ovr |=> s_ff.rxf[scfl_pkg::FL_OVERRUN] && $stable(s_ff.rx_data);
  endproperty
  a_ovr_keep: assert property (p_ovr_keep)
    else $error("overrun lost flag or buffered data");

  property p_edge_set;
    s_ff.rx_on && s_ff.rxd_q && !rxd |=> s_ff.edge_flag;
  endproperty
  a_edge_set: assert property (p_edge_set)
    else $error("rx edge not flagged");

  property p_edge_w0;
    s_ff.edge_flag && wr && hit(paddr, scfl_pkg::OFF_STAT2) &&
      !pwdata[scfl_pkg::POS_EDGE] |=> s_ff.edge_flag;
  endproperty
  a_edge_w0: assert property (p_edge_w0)
    else $error("writing zero cleared edge flag");

  property p_ninth_rx;
    take |=> s_ff.rx_ninth == ($past(s_ff.frame_nine) && $past(rx_char_data[8]));
  endproperty
  a_ninth_rx: assert property (p_ninth_rx)
    else $error("received ninth bit wrong");

  property p_ovr_clear;
    $fell(s_ff.rxf[scfl_pkg::FL_OVERRUN]) |-> $past(dt_rd);
  endproperty
  a_ovr_clear: assert property (p_ovr_clear)
    else $error("overrun cleared without data read");

  c_overrun:  cover property (take ##[1:50] ovr);
  c_edge:     cover property (edge_seen ##[1:20] wr);
  c_nine_bit: cover property (take && s_ff.frame_nine && rx_char_data[8]);
  c_irq:      cover property ($rose(irq));

endmodule : scfl_top

//--- logic/scfl_pkg.sv
package scfl_pkg;

  // Register byte offsets on the APB side
  localparam int         ADDR_W    = 8;
  localparam logic [7:0] OFF_CTRL1 = 8'h00;
  localparam logic [7:0] OFF_CTRL2 = 8'h04;
  localparam logic [7:0] OFF_STAT1 = 8'h08;
  localparam logic [7:0] OFF_STAT2 = 8'h0c;
  localparam logic [7:0] OFF_CTRL3 = 8'h10;
  localparam logic [7:0] OFF_DATA  = 8'h14;
  localparam logic [7:0] OFF_EVT   = 8'h18;
  localparam logic [7:0] OFF_MASK  = 8'h1c;

  // Field positions inside the control and status words
  localparam int POS_FRAME_NINE = 4;
  localparam int POS_RX_ON      = 2;
  localparam int POS_EDGE       = 6;
  localparam int POS_RX_NINTH   = 7;
  localparam int POS_TX_NINTH   = 6;

  // Flag vector layout, shared by status one, event and mask registers
  localparam int FL_W        = 9;
  localparam int RXF_W       = 6;
  localparam int FL_PARITY   = 0;
  localparam int FL_FRAMING  = 1;
  localparam int FL_NOISE    = 2;
  localparam int FL_OVERRUN  = 3;
  localparam int FL_IDLE     = 4;
  localparam int FL_RX_FULL  = 5;
  localparam int FL_TX_DONE  = 6;
  localparam int FL_TX_EMPTY = 7;
  localparam int FL_RX_EDGE  = 8;

  // Reset values
  localparam logic [8:0] FLAGS_RST = 9'h0c0;
  localparam logic [8:0] MASK_RST  = 9'h000;
  localparam logic [5:0] RXF_RST   = 6'h00;

  // APB access sequencer
  typedef enum logic [1:0] {
    ACC_IDLE   = 2'b00,
    ACC_ANSWER = 2'b01
  } scfl_acc_t;

endpackage : scfl_pkg

//--- logic/scfl_tx_if.sv
`timescale 1ns/100ps
interface scfl_tx_if;
  logic       wr;
  logic [7:0] wdata;
  logic       ninth;
  logic       seen;
  logic       tbe;
  logic       tdone;

  modport ctl (output wr, output wdata, output ninth, output seen,
               input tbe, input tdone);
  modport tx  (input wr, input wdata, input ninth, input seen,
               output tbe, output tdone);
endinterface : scfl_tx_if

//--- logic/scfl_tx_hold.sv
`timescale 1ns/100ps
module scfl_tx_hold (
  // Clock and reset
  input  wire logic  pclk,
  input  wire logic  presetn,
  // Control side
  scfl_tx_if.tx      bus,
  // Transmit shifter
  input  wire logic  tx_shift_ready,
  input  wire logic  tx_shift_idle,
  output logic       tx_shift_load,
  output logic [8:0] tx_shift_word
);

  typedef struct packed {
    logic       tbe;
    logic       tdone;
    logic       arm;
    logic [7:0] hold;
    logic [8:0] word;
  } scfl_tx_st_t;

  scfl_tx_st_t s_ff;
  scfl_tx_st_t nxt_s;

  // Shifter takes the buffer only while a character is pending
  assign tx_shift_load = !s_ff.tbe && tx_shift_ready;

  // Buffer, empty flag and done flag
  always_comb begin
    nxt_s = s_ff;
    if (bus.seen) begin
      nxt_s.arm = 1'b1;
    end
    if (bus.wr) begin
      nxt_s.hold = bus.wdata;
      if (s_ff.arm) begin
        nxt_s.tbe   = 1'b0;
        nxt_s.tdone = 1'b0;
        nxt_s.arm   = 1'b0;
      end
    end
    if (tx_shift_load) begin
      nxt_s.word = {bus.ninth, s_ff.hold};
      nxt_s.tbe  = 1'b1;
    end
    // Set wins: done is recomputed after any clear above
    if (nxt_s.tbe && tx_shift_idle) begin
      nxt_s.tdone = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '{tbe: 1'b1, tdone: 1'b1, arm: 1'b0, hold: 8'h00, word: 9'h000};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign bus.tbe       = s_ff.tbe;
  assign bus.tdone     = s_ff.tdone;
  assign tx_shift_word = s_ff.word;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ninth_copied;
    tx_shift_load |=> tx_shift_word[8] == $past(bus.ninth);
  endproperty
  a_ninth_copied: assert property (p_ninth_copied)
    else $error("ninth bit not copied at load");

  property p_empty_after_load;
    tx_shift_load |=> bus.tbe && tx_shift_word[7:0] == $past(s_ff.hold);
  endproperty
  a_empty_after_load: assert property (p_empty_after_load)
    else $error("empty flag not set at load");

  property p_empty_clear;
    $fell(bus.tbe) |-> $past(bus.wr) && $past(s_ff.arm);
  endproperty
  a_empty_clear: assert property (p_empty_clear)
    else $error("empty flag cleared without sequence");

  // Load followed by the shifter finishing, slow shifter included
  c_tx_load: cover property (tx_shift_load ##[1:20] bus.tdone);

endmodule : scfl_tx_hold

//--- tb/scfl_tx_far.sv
`timescale 1ns/100ps
module scfl_tx_far (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Pace of the shifter
  input  wire logic       slow,
  // Shifter handshake
  input  wire logic       tx_shift_load,
  input  wire logic [8:0] tx_shift_word,
  output logic            tx_shift_ready,
  output logic            tx_shift_idle,
  // Characters seen on the line
  output logic [8:0]      last_word,
  output int              count
);
  logic [3:0] busy_ff;
  logic       take_ff;

  // Shifter busy while it sends; slow mode keeps the block waiting longer
  assign tx_shift_ready = (busy_ff == 4'h0);
  assign tx_shift_idle  = (busy_ff == 4'h0) && !take_ff;

  // Word is registered by the block, so it is taken one edge after the load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff   <= 4'h0;
      take_ff   <= 1'b0;
      last_word <= 9'h000;
      count     <= 0;
    end else begin
      take_ff <= tx_shift_load;
      if (tx_shift_load) begin
        busy_ff <= slow ? 4'hc : 4'h1;
      end else if (busy_ff != 4'h0) begin
        busy_ff <= busy_ff - 4'h1;
      end
      if (take_ff) begin
        last_word <= tx_shift_word;
        count     <= count + 1;
      end
    end
  end
endmodule : scfl_tx_far

//--- tb/scfl_tb_top.sv
`timescale 1ns/100ps
module scfl_tb_top;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] r;
    logic        e;
  } scfl_row_t;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr;
  logic        rxd = 1'b1, rx_char_valid = 1'b0, rx_line_idle = 1'b0;
  logic [8:0]  rx_char_data = 9'h000;
  logic        rx_noise = 1'b0, rx_framing = 1'b0, rx_parity = 1'b0;
  logic        tx_shift_ready, tx_shift_idle, tx_shift_load, irq, slow = 1'b0;
  logic [8:0]  tx_shift_word, last_word;
  int          count, miscompares = 0, checks = 0, cycles = 0;
  scfl_row_t   rows [8];

  // Clock, and a watchdog far above the few hundred cycles the tests need
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  scfl_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rxd(rxd), .rx_char_valid(rx_char_valid),
    .rx_char_data(rx_char_data), .rx_noise(rx_noise), .rx_framing(rx_framing),
    .rx_parity(rx_parity), .rx_line_idle(rx_line_idle), .tx_shift_ready(tx_shift_ready),
    .tx_shift_idle(tx_shift_idle), .tx_shift_load(tx_shift_load),
    .tx_shift_word(tx_shift_word), .irq(irq));

  scfl_tx_far u_far (.pclk(pclk), .presetn(presetn), .slow(slow),
    .tx_shift_load(tx_shift_load), .tx_shift_word(tx_shift_word),
    .tx_shift_ready(tx_shift_ready), .tx_shift_idle(tx_shift_idle),
    .last_word(last_word), .count(count));

  // Compare tasks: one for words, one for single bits
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: bit got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  // APB master; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd

  // One character from the receive shifter, errors as {noise, framing, parity}
  task automatic rx_char(input logic [8:0] d, input logic [2:0] e);
    rx_char_valid <= 1'b1;
    rx_char_data  <= d;
    {rx_noise, rx_framing, rx_parity} <= e;
    @(posedge pclk);
    rx_char_valid <= 1'b0;
    {rx_noise, rx_framing, rx_parity} <= 3'b000;
    @(posedge pclk);
  endtask : rx_char

  task automatic do_reset();
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_reset

  // Reset values of every register except data, plus an unmapped place
  task automatic run_rows();
    logic [31:0] r;
    logic        e;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0, r, e);
      chk(r, rows[i].r);
      chk_bit(e, rows[i].e);
    end
    $display("Register table done");
  endtask : run_rows

  // Send one character: status read first, then data, then wait for the shifter
  task automatic send(input logic [7:0] d, input logic [8:0] exp);
    logic [31:0] r;
    int          c, n;
    c = count;
    n = 0;
    rd(scfl_pkg::OFF_STAT1, r);
    wr(scfl_pkg::OFF_DATA, {24'h0, d});
    while (count == c && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk({23'h0, last_word}, {23'h0, exp});
  endtask : send

  task automatic stop_test();
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    logic [31:0] r;
    logic        e;
    int          c;
    rows = '{'{scfl_pkg::OFF_STAT1, 32'h0c0, 1'b0}, '{scfl_pkg::OFF_CTRL1, 32'h0, 1'b0},
             '{scfl_pkg::OFF_CTRL2, 32'h0, 1'b0},   '{scfl_pkg::OFF_STAT2, 32'h0, 1'b0},
             '{scfl_pkg::OFF_CTRL3, 32'h0, 1'b0},   '{scfl_pkg::OFF_EVT, 32'h0, 1'b0},
             '{scfl_pkg::OFF_MASK, 32'h0, 1'b0},    '{8'h20, 32'h0, 1'b1}};
    do_reset();
    run_rows();
    chk_bit(irq, 1'b0);
    // Edge ignored with receiver off, then set and cleared by writing one
    rxd <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(scfl_pkg::OFF_STAT2, r);
    chk(r, 32'h0);
    rxd <= 1'b1;
    wr(scfl_pkg::OFF_CTRL2, 32'h4);
    rxd <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(scfl_pkg::OFF_STAT2, r);
    chk(r, 32'h40);
    wr(scfl_pkg::OFF_STAT2, 32'h0);
    rd(scfl_pkg::OFF_STAT2, r);
    chk(r, 32'h40);
    wr(scfl_pkg::OFF_STAT2, 32'h40);
    rd(scfl_pkg::OFF_STAT2, r);
    chk(r, 32'h0);
    rxd <= 1'b1;
    $display("Edge flag test done");
    // Error flags come with full; data read alone leaves flags set
    rx_char(9'h15a, 3'b010);
    rd(scfl_pkg::OFF_CTRL3, r);
    chk(r, 32'h0);
    rd(scfl_pkg::OFF_DATA, r);
    chk(r, 32'h5a);
    rd(scfl_pkg::OFF_STAT1, r);
    chk(r, 32'he2);
    rd(scfl_pkg::OFF_DATA, r);
    rd(scfl_pkg::OFF_STAT1, r);
    chk(r, 32'hc0);
    // Overrun keeps old character and drops the new one with its errors
    rx_char(9'h011, 3'b000);
    rx_char(9'h022, 3'b101);
    rd(scfl_pkg::OFF_STAT1, r);
    chk(r, 32'he8);
    rd(scfl_pkg::OFF_DATA, r);
    chk(r, 32'h11);
    rd(scfl_pkg::OFF_STAT1, r);
    chk(r, 32'hc0);
    $display("Receive flags test done");
    // Idle sets once per received character
    rx_line_idle <= 1'b1;
    @(posedge pclk);
    rx_line_idle <= 1'b0;
    rd(scfl_pkg::OFF_STAT1, r);
    chk(r, 32'hd0);
    rd(scfl_pkg::OFF_DATA, r);
    rx_line_idle <= 1'b1;
    @(posedge pclk);
    rx_line_idle <= 1'b0;
    rd(scfl_pkg::OFF_STAT1, r);
    chk(r, 32'hc0);
    $display("Idle test done");
    // Nine-bit transmit; ninth bit written before data and reused
    wr(scfl_pkg::OFF_EVT, 32'h1ff);
    wr(scfl_pkg::OFF_CTRL1, 32'h10);
    wr(scfl_pkg::OFF_CTRL3, 32'h40);
    send(8'ha5, 9'h1a5);
    slow <= 1'b1;
    send(8'h3c, 9'h13c);
    rd(scfl_pkg::OFF_CTRL3, r);
    chk(r, 32'h40);
    // Data write with no status read in between must not send
    c = count;
    wr(scfl_pkg::OFF_DATA, 32'h77);
    repeat (20) @(posedge pclk);
    chk(count, c);
    rd(scfl_pkg::OFF_STAT1, r);
    chk(r, 32'hc0);
    // Nine-bit receive: ninth bit appears in control three
    rx_char(9'h1b7, 3'b000);
    rd(scfl_pkg::OFF_CTRL3, r);
    chk(r, 32'hc0);
    rd(scfl_pkg::OFF_STAT1, r);
    rd(scfl_pkg::OFF_DATA, r);
    chk(r, 32'hb7);
    $display("Nine-bit test done");
    // Interrupt: masked event is pollable only, unmasked raises, clear drops
    chk_bit(irq, 1'b0);
    wr(scfl_pkg::OFF_MASK, 32'h80);
    repeat (2) @(posedge pclk);
    chk_bit(irq, 1'b1);
    wr(scfl_pkg::OFF_EVT, 32'h1ff);
    repeat (2) @(posedge pclk);
    chk_bit(irq, 1'b0);
    $display("Interrupt test done");
    // Reset in mid-run restores the reset values; all but the data register's are checked again
    rx_char(9'h0aa, 3'b000);
    do_reset();
    run_rows();
    stop_test();
  end
endmodule : scfl_tb_top
